//--- ctw_params.svh
// Offsets, reset values and timing figures of the threshold and wake registers
`ifndef CTW_PARAMS_SVH
`define CTW_PARAMS_SVH
// Register indices; byte address is four times the index
`define CTW_IDX_ZERO_LIMIT 6'h19
`define CTW_IDX_ONE_LIMIT 6'h1A
`define CTW_IDX_WAKE_EN 6'h1C
`define CTW_IDX_WAKE_PEND 6'h1D
`define CTW_IDX_EVT_STATUS 6'h30
`define CTW_IDX_EVT_MASK 6'h31
`define CTW_IDX_CODE_CFG 6'h32
// Field positions
`define CTW_LIMIT_MSB 6
`define CTW_WAKE_BIT 0
`define CTW_CODE64_BIT 0
`define CTW_EVT_ONE_BIT 0
`define CTW_EVT_ZERO_BIT 1
`define CTW_EVT_BAD_BIT 2
// Reset values
`define CTW_ONE_LIMIT_RST 7'h38
`define CTW_ZERO_LIMIT_RST 7'h08
`define CTW_WAKE_EN_RST 1'h0
`define CTW_WAKE_PEND_RST 1'h1
`define CTW_CODE64_RST 1'h1
// Code lengths in chips per bit
`define CTW_LEN_64 7'h40
`define CTW_LEN_32 7'h20
// Timing: serial port ready delay after power-down release
`define CTW_READY_NS 1000
`define CTW_CLK_NS 40
`endif

//--- ctw_pkg.sv
// Types shared by the threshold and wake register block
package ctw_pkg;
    typedef enum logic [1:0] {
        CTW_WK_DOWN = 2'b00,
        CTW_WK_WAIT = 2'b01,
        CTW_WK_UP = 2'b10
    } ctw_wake_st_t;

    typedef struct packed {
        logic valid;
        logic [6:0] count;
    } ctw_corr_in_t;

    typedef struct packed {
        logic valid;
        logic one;
        logic invalid;
    } ctw_bit_out_t;

    typedef struct packed {
        logic pd_s1;
        logic pd_s2;
        logic wait_r;
        logic [7:0] rdata;
        logic [6:0] one_limit;
        logic [6:0] zero_limit;
        logic wake_en;
        logic wake_pend;
        logic code64;
        logic [2:0] evt_status;
        logic [2:0] evt_mask;
        ctw_wake_st_t wk_st;
        logic [7:0] rdy_cnt;
        logic ser_ready;
        ctw_bit_out_t bit_out;
        logic irq;
    } ctw_state_t;
endpackage

//--- ctw_regs.sv
// Correlator thresholds, wake logic and Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
`include "ctw_params.svh"

// Behaviour
// [RULE_01] Seven-bit one limit, bits 6:0, is the match count accepting a one.
// [RULE_02] Error-free one gives match count equal to code length, 64 or 32.
// [RULE_03] One limit resets to 0x38, tolerating eight bad chips at 64 chips.
// [RULE_04] Each bit is decided against both the one and zero limits.
// [RULE_05] Zero limit gives most matches still accepted as zero; resets 0x08.
// [RULE_06] Counts strictly between the limits give neither zero nor one.
// [RULE_07] Software writes zero to reserved bit 7 of the one limit.
// [RULE_08] Power-down release plus serial readiness raises a wake; enable resets off.
// [RULE_09] Software writes zeroes to reserved bits 7:1 of wake enable.
// [RULE_10] Wake status bit 0 shows pending wake; register resets to 0x01.
// [RULE_11] Interrupt request asserts when a wake sets the pending flag; the code raises it only while wake enable is set.
// [RULE_12] Reading wake status clears the pending flag, and nothing else does.
// [RULE_13] Wake status is read-only; writes to it have no effect.
module ctw_regs
    import ctw_pkg::*;
#(
    parameter int READY_NS = `CTW_READY_NS
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic power_down_pin,
    input wire ctw_corr_in_t corr_in,
    output ctw_bit_out_t bit_out,
    output logic serial_ready,
    output logic irq
);
    // Ready delay in cycles, rounded up, at least one
    localparam int READY_RAW = (READY_NS + `CTW_CLK_NS - 1) / `CTW_CLK_NS;
    localparam int READY_CYC = (READY_RAW < 1) ? 1 : READY_RAW;
    localparam logic [7:0] READY_LAST = 8'(READY_CYC - 1);

    // [RULE_03] [RULE_05] limit reset values
    localparam ctw_state_t ST_RST = '{
        pd_s1: 1'b1,
        pd_s2: 1'b1,
        wait_r: 1'b1,
        rdata: 8'h00,
        one_limit: `CTW_ONE_LIMIT_RST,
        zero_limit: `CTW_ZERO_LIMIT_RST,
        wake_en: `CTW_WAKE_EN_RST,
        wake_pend: `CTW_WAKE_PEND_RST,
        code64: `CTW_CODE64_RST,
        evt_status: 3'h0,
        evt_mask: 3'h0,
        wk_st: CTW_WK_DOWN,
        rdy_cnt: 8'h00,
        ser_ready: 1'b0,
        bit_out: '{valid: 1'b0, one: 1'b0, invalid: 1'b0},
        irq: 1'b0
    };

    ctw_state_t st;
    ctw_state_t nx;

    logic rd_acc;
    logic wr_acc;
    logic wr_lane0;
    logic wake_evt;
    logic [6:0] code_len;
    logic [2:0] evt_set;
    logic is_one;
    logic is_zero;
    logic len_ok;

    // Word index match on an aligned byte address
    function automatic logic hit(input logic [7:0] addr, input logic [5:0] idx);
        hit = (addr[1:0] == 2'h0) && (addr[7:2] == idx);
    endfunction

    // [RULE_10] pending flag readback
    // Read value of the addressed register, zero when unmapped
    function automatic logic [7:0] read_mux(input logic [7:0] addr, input ctw_state_t s);
        read_mux = 8'h00;
        if (hit(addr, `CTW_IDX_ZERO_LIMIT)) begin
            read_mux = {1'b0, s.zero_limit};
        end else if (hit(addr, `CTW_IDX_ONE_LIMIT)) begin
            read_mux = {1'b0, s.one_limit};
        end else if (hit(addr, `CTW_IDX_WAKE_EN)) begin
            read_mux = {7'h00, s.wake_en};
        end else if (hit(addr, `CTW_IDX_WAKE_PEND)) begin
            read_mux = {7'h00, s.wake_pend};
        end else if (hit(addr, `CTW_IDX_EVT_STATUS)) begin
            read_mux = {5'h00, s.evt_status};
        end else if (hit(addr, `CTW_IDX_EVT_MASK)) begin
            read_mux = {5'h00, s.evt_mask};
        end else if (hit(addr, `CTW_IDX_CODE_CFG)) begin
            read_mux = {7'h00, s.code64};
        end
    endfunction

    // Bus handshake: a request is accepted on the edge where waitrequest is low
    assign rd_acc = avs_read & ~st.wait_r;
    assign wr_acc = avs_write & ~avs_read & ~st.wait_r;
    assign wr_lane0 = wr_acc & avs_byteenable[0];

    // [RULE_08] wake on ready delay expiry, pin still released
    assign wake_evt = (st.wk_st == CTW_WK_WAIT) && !st.pd_s2 && (st.rdy_cnt == READY_LAST);

    // [RULE_02] expected match count of a perfect one
    assign code_len = st.code64 ? `CTW_LEN_64 : `CTW_LEN_32;
    assign len_ok = corr_in.count <= code_len;

    // [RULE_04] decision against both limits
    assign is_one = len_ok && (corr_in.count >= st.one_limit);
    assign is_zero = len_ok && !is_one && (corr_in.count <= st.zero_limit);

    // Correlator events for the status register
    always_comb begin
        evt_set = 3'h0;
        evt_set[`CTW_EVT_ONE_BIT] = corr_in.valid & is_one;
        evt_set[`CTW_EVT_ZERO_BIT] = corr_in.valid & is_zero;
        evt_set[`CTW_EVT_BAD_BIT] = corr_in.valid & !is_one & !is_zero;
    end

    // Next state of the whole block
    always_comb begin
        nx = st;
        // Power-down pin synchroniser
        nx.pd_s1 = power_down_pin;
        nx.pd_s2 = st.pd_s1;

        // One wait cycle, then answer with the captured read data
        nx.wait_r = 1'b1;
        if ((avs_read | avs_write) & st.wait_r) begin
            nx.wait_r = 1'b0;
            nx.rdata = read_mux(avs_address, st);
        end

        // [RULE_07] reserved bit 7 is dropped on write
        if (wr_lane0 && hit(avs_address, `CTW_IDX_ONE_LIMIT)) begin
            nx.one_limit = avs_writedata[`CTW_LIMIT_MSB:0];
        end
        // [RULE_05] zero limit write
        if (wr_lane0 && hit(avs_address, `CTW_IDX_ZERO_LIMIT)) begin
            nx.zero_limit = avs_writedata[`CTW_LIMIT_MSB:0];
        end
        // [RULE_09] only the enable bit is kept
        if (wr_lane0 && hit(avs_address, `CTW_IDX_WAKE_EN)) begin
            nx.wake_en = avs_writedata[`CTW_WAKE_BIT];
        end
        if (wr_lane0 && hit(avs_address, `CTW_IDX_EVT_MASK)) begin
            nx.evt_mask = avs_writedata[2:0];
        end
        if (wr_lane0 && hit(avs_address, `CTW_IDX_CODE_CFG)) begin
            nx.code64 = avs_writedata[`CTW_CODE64_BIT];
        end

        // [RULE_12] read clears only what was returned; a new wake wins
        // [RULE_13] no write path reaches the pending flag
        if (rd_acc && hit(avs_address, `CTW_IDX_WAKE_PEND)) begin
            nx.wake_pend = st.wake_pend & ~st.rdata[`CTW_WAKE_BIT];
        end
        if (wake_evt) begin
            nx.wake_pend = 1'b1;
        end

        // Event status: read clears returned bits, set wins
        if (rd_acc && hit(avs_address, `CTW_IDX_EVT_STATUS)) begin
            nx.evt_status = st.evt_status & ~st.rdata[2:0];
        end
        nx.evt_status = nx.evt_status | evt_set;

        // [RULE_08] power-down release, ready delay, then serial ready
        unique case (st.wk_st)
            CTW_WK_DOWN: begin
                nx.ser_ready = 1'b0;
                nx.rdy_cnt = 8'h00;
                if (!st.pd_s2) begin
                    nx.wk_st = CTW_WK_WAIT;
                end
            end
            CTW_WK_WAIT: begin
                nx.rdy_cnt = st.rdy_cnt + 8'h01;
                if (st.pd_s2) begin
                    nx.wk_st = CTW_WK_DOWN;
                end else if (wake_evt) begin
                    nx.wk_st = CTW_WK_UP;
                    nx.ser_ready = 1'b1;
                end
            end
            CTW_WK_UP: begin
                if (st.pd_s2) begin
                    nx.wk_st = CTW_WK_DOWN;
                    nx.ser_ready = 1'b0;
                end
            end
            default: begin
                nx.wk_st = CTW_WK_DOWN;
            end
        endcase

        // [RULE_01] [RULE_06] registered bit decision
        nx.bit_out.valid = corr_in.valid & (is_one | is_zero);
        nx.bit_out.one = corr_in.valid & is_one;
        nx.bit_out.invalid = corr_in.valid & !is_one & !is_zero;

        // [RULE_11] interrupt level from the next flag values
        nx.irq = (nx.wake_pend & nx.wake_en) | (|(nx.evt_status & nx.evt_mask));
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            st <= ST_RST;
        end else begin
            st <= nx;
        end
    end

    // Outputs straight from the state flip-flops
    assign avs_readdata = {24'h000000, st.rdata};
    assign avs_waitrequest = st.wait_r;
    assign bit_out = st.bit_out;
    assign serial_ready = st.ser_ready;
    assign irq = st.irq;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    one_decision_a: assert property ( // [RULE_01]
        corr_in.valid && len_ok && corr_in.count >= st.one_limit |=> bit_out.valid && bit_out.one)
        else $error("accepted one not reported");

    code_len_a: assert property ( // [RULE_02]
        corr_in.valid && st.code64 && corr_in.count > 7'h40 |=> bit_out.invalid && !bit_out.valid)
        else $error("count above code length accepted");

    limit_reset_a: assert property ( // [RULE_03]
        $rose(reset_n) |-> st.one_limit == 7'h38 && st.zero_limit == 7'h08)
        else $error("limit reset value wrong");

    zero_decision_a: assert property ( // [RULE_05]
        corr_in.valid && corr_in.count <= st.zero_limit && corr_in.count < st.one_limit
        |=> bit_out.valid && !bit_out.one)
        else $error("accepted zero not reported");

    gap_reject_a: assert property ( // [RULE_06]
        corr_in.valid && corr_in.count > st.zero_limit && corr_in.count < st.one_limit
        |=> bit_out.invalid && !bit_out.valid)
        else $error("count between limits accepted");

    wake_event_a: assert property ( // [RULE_08]
        st.wk_st == CTW_WK_DOWN && !st.pd_s2 && !st.pd_s1 && !power_down_pin
        |=> ##[READY_CYC:READY_CYC] st.wake_pend && serial_ready)
        else $error("wake not raised after ready delay");

    wake_irq_a: assert property ( // [RULE_11]
        wake_evt && st.wake_en && !(avs_write && hit(avs_address, `CTW_IDX_WAKE_EN)) |=> irq)
        else $error("wake did not raise interrupt");

    pend_clear_a: assert property ( // [RULE_12]
        rd_acc && hit(avs_address, `CTW_IDX_WAKE_PEND) && st.rdata[0] && !wake_evt |=> !st.wake_pend)
        else $error("read did not clear pending flag");

    pend_hold_a: assert property ( // [RULE_13]
        st.wake_pend && !(rd_acc && hit(avs_address, `CTW_IDX_WAKE_PEND)) |=> st.wake_pend)
        else $error("pending flag lost without read");

    status_read_a: assert property ( // [RULE_10]
        rd_acc && hit(avs_address, `CTW_IDX_WAKE_PEND) |-> avs_readdata == {31'h0, $past(st.wake_pend)})
        else $error("wake status read value wrong");

    bus_answer_a: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered in one cycle");

    // Register storage, bit decision, wake sequencing, interrupt level, event status and handshake checks
    one_write_a: assert property ( // [RULE_01]
        wr_lane0 && hit(avs_address, `CTW_IDX_ONE_LIMIT) |=> st.one_limit == $past(avs_writedata[`CTW_LIMIT_MSB:0]))
        else $error("one limit write not stored");

    one_keep_a: assert property ( // [RULE_01]
        !(wr_lane0 && hit(avs_address, `CTW_IDX_ONE_LIMIT)) |=> $stable(st.one_limit))
        else $error("one limit changed without write");

    zero_write_a: assert property ( // [RULE_05]
        wr_lane0 && hit(avs_address, `CTW_IDX_ZERO_LIMIT) |=> st.zero_limit == $past(avs_writedata[`CTW_LIMIT_MSB:0]))
        else $error("zero limit write not stored");

    zero_keep_a: assert property ( // [RULE_05]
        !(wr_lane0 && hit(avs_address, `CTW_IDX_ZERO_LIMIT)) |=> $stable(st.zero_limit))
        else $error("zero limit changed without write");

    short_code_a: assert property ( // [RULE_02]
        corr_in.valid && !st.code64 && corr_in.count > 7'h20 |=> bit_out.invalid && !bit_out.valid)
        else $error("count above short code length accepted");

    idle_quiet_a: assert property ( // [RULE_04]
        !corr_in.valid |=> !bit_out.valid && !bit_out.one && !bit_out.invalid)
        else $error("decision without correlator sample");

    enable_write_a: assert property ( // [RULE_08]
        wr_lane0 && hit(avs_address, `CTW_IDX_WAKE_EN) |=> st.wake_en == $past(avs_writedata[`CTW_WAKE_BIT]))
        else $error("wake enable write not stored");

    enable_keep_a: assert property ( // [RULE_08]
        !(wr_lane0 && hit(avs_address, `CTW_IDX_WAKE_EN)) |=> $stable(st.wake_en))
        else $error("wake enable changed without write");

    down_quiet_a: assert property ( // [RULE_08]
        st.wk_st == CTW_WK_DOWN |-> !serial_ready)
        else $error("serial ready while powered down");

    abort_quiet_a: assert property ( // [RULE_08]
        st.wk_st == CTW_WK_WAIT && st.pd_s2 && !st.wake_pend |=> !st.wake_pend)
        else $error("aborted wake set pending flag");

    wake_set_a: assert property ( // [RULE_10]
        wake_evt |=> st.wake_pend)
        else $error("wake event did not set pending flag");

    irq_on_a: assert property ( // [RULE_11]
        st.wake_pend && st.wake_en |-> irq)
        else $error("pending enabled wake without interrupt");

    irq_off_a: assert property ( // [RULE_11]
        !st.wake_pend && !(|(st.evt_status & st.evt_mask)) |-> !irq)
        else $error("interrupt without pending cause");

    write_ignored_a: assert property ( // [RULE_13]
        wr_acc && hit(avs_address, `CTW_IDX_WAKE_PEND) && !wake_evt |=> st.wake_pend == $past(st.wake_pend))
        else $error("write changed pending flag");

    evt_sticky_a: assert property (
        corr_in.valid && is_one |=> st.evt_status[`CTW_EVT_ONE_BIT])
        else $error("accepted one not recorded in status");

    wait_pulse_a: assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
endmodule
`default_nettype wire

//--- ctw_mcu_model.sv
// Microcontroller model driving the register port of the threshold and wake block
`timescale 1ns/1ps
`default_nettype none
module ctw_mcu_model (
    input wire logic ref_clk,
    output logic [7:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [3:0] avs_byteenable,
    output logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    // Idle bus from time zero
    initial begin
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_byteenable = 4'h0;
        avs_writedata = 32'h0;
    end

    // One register cycle, held until waitrequest is sampled low
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                          input logic [3:0] be, output logic [7:0] rdata, output logic ok);
        int n;
        logic [7:0] d;
        begin
            n = 0;
            d = wdata;
            if (addr == 8'h68) d[7] = 1'b0;
            if (addr == 8'h70) d[7:1] = 7'h00;
            avs_address <= addr;
            avs_write <= wr;
            avs_read <= !wr;
            avs_byteenable <= be;
            avs_writedata <= {24'h0, d};
            // Look just after each edge: that value is what the next edge samples
            @(posedge ref_clk);
            #1;
            while (avs_waitrequest !== 1'b0 && n < 50) begin
                @(posedge ref_clk);
                #1;
                n++;
            end
            // Read data stands until the edge that completes the transfer
            rdata = avs_readdata[7:0];
            ok = (n < 50);
            @(posedge ref_clk);
            // Release; idle lines show inverted values
            avs_read <= 1'b0;
            avs_write <= 1'b0;
            avs_address <= ~addr;
            avs_writedata <= ~{24'h0, d};
            @(posedge ref_clk);
        end
    endtask
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking testbench of the threshold and wake register block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ctw_pkg::*;
    logic ref_clk, reset_n, power_down_pin, avs_read, avs_write, avs_waitrequest, serial_ready, irq;
    logic [7:0] avs_address, q;
    logic [3:0] avs_byteenable, lane_en;
    logic [31:0] avs_writedata, avs_readdata, rnd;
    ctw_corr_in_t corr_in;
    ctw_bit_out_t bit_out;
    logic [6:0] one_lim, zero_lim, len, cnt;
    logic [2:0] acc;
    int fail_count, n_tests;

    ctw_regs #(.READY_NS(40)) dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .power_down_pin(power_down_pin), .corr_in(corr_in), .bit_out(bit_out),
        .serial_ready(serial_ready), .irq(irq));
    ctw_mcu_model mcu_u (.ref_clk(ref_clk), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

    // Clock of 40 ns period
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic bad(input string msg);
        fail_count++;
        $display("BAD %0t %s", $time, msg);
    endtask

    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) bad($sformatf("value %h expected %h", got, exp));
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) bad($sformatf("flag %b expected %b", got, exp));
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic rw(input logic wr, input logic [7:0] a, input logic [7:0] d);
        logic ok;
        mcu_u.access(wr, a, d, lane_en, q, ok);
        if (!ok) begin
            bad("bus timeout");
            stop_test();
        end
    endtask

    // One correlator sample and its decision one cycle later
    task automatic corr(input logic [6:0] c);
        logic one, zero;
        corr_in <= '{valid: 1'b1, count: c};
        @(posedge ref_clk);
        corr_in.valid <= 1'b0;
        #1;
        one = (c >= one_lim) && (c <= len);
        zero = !one && (c <= zero_lim) && (c <= len);
        acc = acc | {!one && !zero, zero, one};
        chk_val({5'h0, bit_out.valid, bit_out.one, bit_out.invalid},
            {5'h0, one || zero, one, !one && !zero});
        @(posedge ref_clk);
    endtask

    initial begin
        fail_count = 0;
        n_tests = 0;
        rnd = 32'h9c2c;
        acc = 3'h0;
        lane_en = 4'hF;
        reset_n = 1'b0;
        power_down_pin = 1'b1;
        corr_in = '{valid: 1'b0, count: 7'h00};
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        // Reset values and read-clear
        rw(0, 8'h68, 8'h00); chk_val(q, 8'h38);
        rw(0, 8'h64, 8'h00); chk_val(q, 8'h08);
        rw(0, 8'h70, 8'h00); chk_val(q, 8'h00);
        rw(0, 8'h74, 8'h00); chk_val(q, 8'h01);
        rw(0, 8'h74, 8'h00); chk_val(q, 8'h00);
        chk_flag(irq, 1'b0);
        $display("reset test done");
        // Read-only status, unmapped place, limit width
        rw(1, 8'h74, 8'hFF); rw(0, 8'h74, 8'h00); chk_val(q, 8'h00);
        rw(1, 8'h04, 8'hFF); rw(0, 8'h04, 8'h00); chk_val(q, 8'h00);
        rw(1, 8'h68, 8'hFF); rw(0, 8'h68, 8'h00); chk_val(q, 8'h7F);
        // Write with lane 0 disabled must leave the limit alone
        lane_en = 4'hE;
        rw(1, 8'h68, 8'h11);
        lane_en = 4'hF;
        rw(0, 8'h68, 8'h00); chk_val(q, 8'h7F);
        $display("access test done");
        // Wake event with interrupt enabled
        rw(1, 8'h70, 8'hFF); rw(0, 8'h70, 8'h00); chk_val(q, 8'h01);
        power_down_pin <= 1'b0;
        for (int i = 0; i < 60 && irq !== 1'b1; i++) @(posedge ref_clk);
        chk_flag(irq, 1'b1);
        chk_flag(serial_ready, 1'b1);
        rw(0, 8'h74, 8'h00); chk_val(q, 8'h01);
        repeat (2) @(posedge ref_clk);
        chk_flag(irq, 1'b0);
        $display("wake test done");
        // Random and corner counts for both code lengths
        for (int m = 0; m < 2; m++) begin
            len = m ? 7'h20 : 7'h40;
            rnd = lfsr_next(rnd);
            one_lim = len - 7'(rnd % 9);
            zero_lim = 7'(rnd[15:8] % 9);
            rw(1, 8'hC8, {7'h0, m == 0});
            rw(1, 8'h68, {1'b0, one_lim});
            rw(1, 8'h64, {1'b0, zero_lim});
            corr(one_lim);
            corr(one_lim - 7'h1);
            corr(zero_lim);
            corr(zero_lim + 7'h1);
            corr(len);
            corr(len + 7'h1);
            for (int i = 0; i < 40; i++) begin
                rnd = lfsr_next(rnd);
                cnt = 7'(rnd % (len + 8));
                corr(cnt);
            end
        end
        $display("correlator test done");
        // Event interrupt: masked, unmasked, cleared by read
        chk_flag(irq, 1'b0);
        rw(1, 8'hC4, 8'h07);
        repeat (2) @(posedge ref_clk);
        chk_flag(irq, |acc);
        rw(0, 8'hC0, 8'h00); chk_val(q, {5'h0, acc});
        repeat (2) @(posedge ref_clk);
        chk_flag(irq, 1'b0);
        $display("event test done");
        stop_test();
    end
endmodule
`default_nettype wire
